// file: logic/dcrc_defs.svh
// Purpose: Shared constants of the converter control core
// Assumes: Included by bare name from the package and the core module
// Notes:   Definitions only
`ifndef DCRC_DEFS_SVH
`define DCRC_DEFS_SVH

`define DCRC_ADDR_W          5
`define DCRC_WORD_W          16
`define DCRC_OP_W            2
`define DCRC_SEL_W           2
`define DCRC_ADDR_CH0        5'h00
`define DCRC_ADDR_CH1        5'h01
`define DCRC_ADDR_VREF       5'h08
`define DCRC_ADDR_PD         5'h09
`define DCRC_ADDR_GAIN       5'h0A
`define DCRC_OP_WRITE        2'h0
`define DCRC_OP_READ         2'h3
`define DCRC_CMD_ADDR_LSB    3
`define DCRC_CMD_OP_LSB      1
`define DCRC_CMD_LAST        5'h07
`define DCRC_FRAME_LAST      5'h17
`define DCRC_POR_BIT         7
`define DCRC_GAIN_LSB        8
`define DCRC_PD_OFF          2'h3
`define DCRC_SEL_RESET       2'h0
`define DCRC_SYS_CLK_NS      5
`define DCRC_RESET_DELAY_NS  1000

`endif

// file: logic/dcrc_pkg.sv
// Purpose: Types shared between the core's system and link logic
// Assumes: Constants come from dcrc_defs.svh
// Notes:   Nothing here is imported; users write dcrc_pkg::name
`include "dcrc_defs.svh"

package dcrc_pkg;

   typedef struct packed {
      logic [`DCRC_ADDR_W-1:0] addr;
      logic [`DCRC_WORD_W-1:0] data;
   } dcrc_wr_s;

   typedef struct packed {
      logic [`DCRC_WORD_W-1:0] ch0;
      logic [`DCRC_WORD_W-1:0] ch1;
      logic [`DCRC_WORD_W-1:0] vref;
      logic [`DCRC_WORD_W-1:0] pd;
      logic [`DCRC_WORD_W-1:0] gain;
   } dcrc_shadow_s;

   typedef enum logic [1:0] {LINK_CMD, LINK_DATA, LINK_DONE} dcrc_link_e;

   typedef enum logic [1:0] {PWR_DELAY, PWR_RUN, PWR_DROP} dcrc_pwr_e;

endpackage

// file: logic/dcrc_sync.sv
// Purpose: Two-flop synchroniser for a group of levels
// Assumes: Synchronous active-high reset
// Notes:   First stage feeds only the second
`timescale 1ns/1ps

module dcrc_sync #(
   parameter int unsigned     WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_reg <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// file: logic/dcrc_delay_timer.sv
// Purpose: Start-up delay counter
// Assumes: Held in restart while not counting
// Notes:   done stays high until the next restart
`timescale 1ns/1ps

module dcrc_delay_timer #(
   parameter int unsigned CYCLES = 200
) (
   input  wire logic clk,
   input  wire logic restart,
   output logic      done
);

   localparam int unsigned CW = $clog2(CYCLES + 1);

   logic [CW-1:0] count_reg;

   always_ff @(posedge clk) begin
      if (restart) begin
         count_reg <= '0;
         done      <= 1'b0;
      end else if (!done) begin
         count_reg <= count_reg + CW'(1);
         done      <= (count_reg == CW'(CYCLES - 1));
      end
   end

endmodule

// file: logic/dcrc_core.sv
// Purpose: Register core of a one- or two-channel voltage-output converter
// Assumes: SPI mode 0 host; sys_clk 200 MHz; reset is the power-on event
// Notes:   Frame: 8 command bits then 16 data bits, MSB first
`timescale 1ns/1ps
`include "dcrc_defs.svh"

module dcrc_core #(
   parameter int unsigned RES_BITS     = 12,
   parameter int unsigned CHANNELS     = 2,
   parameter int unsigned DELAY_CYCLES =
      (`DCRC_RESET_DELAY_NS + `DCRC_SYS_CLK_NS - 1) / `DCRC_SYS_CLK_NS
) (
   input  wire logic                               sys_clk,
   input  wire logic                               reset,
   input  wire logic                               supply_dropout_event,
   input  wire logic                               latch_update_pin_n,
   input  wire logic                               spi_sck,
   input  wire logic                               spi_cs_n,
   input  wire logic                               spi_sdi,
   output logic                                    spi_sdo,
   output logic                                    spi_sdo_oe,
   output logic [CHANNELS-1:0][RES_BITS-1:0]       channel_value,
   output logic [CHANNELS-1:0][`DCRC_SEL_W-1:0]    reference_select_field,
   output logic [CHANNELS-1:0][`DCRC_SEL_W-1:0]    power_down_select_field,
   output logic [CHANNELS-1:0]                     gain_select_bit,
   output logic                                    por_status,
   output logic                                    link_ready
);

   localparam logic [RES_BITS-1:0] MID_SCALE = {1'b0, {(RES_BITS-1){1'b1}}};

   // Host clock only samples; nothing here drives spi_sck
   // ---------------- System domain ----------------
   logic [3:0]              sync_in;
   logic [3:0]              sync_out;
   logic                    drop_s;
   logic                    lat_n_s;
   logic                    cs_n_s;
   logic                    tog_s;
   logic                    drop_d_reg;
   logic                    tog_d_reg;
   logic                    drop_fall;
   logic                    por_load;
   logic                    wr_accept;
   logic                    timer_done;
   dcrc_pkg::dcrc_pwr_e     pwr_reg;
   dcrc_pkg::dcrc_wr_s      wr_word_reg;
   dcrc_pkg::dcrc_shadow_s  shadow_reg;

   logic [CHANNELS-1:0][RES_BITS-1:0]    stage_val_reg;
   logic [CHANNELS-1:0][RES_BITS-1:0]    act_val_reg;
   logic [CHANNELS-1:0][`DCRC_SEL_W-1:0] stage_vref_reg;
   logic [CHANNELS-1:0][`DCRC_SEL_W-1:0] act_vref_reg;
   logic [CHANNELS-1:0][`DCRC_SEL_W-1:0] stage_pd_reg;
   logic [CHANNELS-1:0][`DCRC_SEL_W-1:0] act_pd_reg;
   logic [CHANNELS-1:0]                  stage_gain_reg;
   logic [CHANNELS-1:0]                  act_gain_reg;
   logic                                 por_reg;
   logic                                 ready_reg;

   // ---------------- Link domain ----------------
   logic                    wr_flag_reg;
   logic                    rdy_meta_reg;
   logic                    rdy_sync_reg;
   dcrc_pkg::dcrc_link_e    link_reg;
   logic [4:0]              bit_cnt_reg;
   logic [6:0]              cmd_shift_reg;
   logic [`DCRC_WORD_W-2:0] data_shift_reg;
   logic [`DCRC_ADDR_W-1:0] addr_reg;
   logic                    op_write_reg;
   logic                    command_error_flag;
   logic [`DCRC_WORD_W-1:0] rd_word_reg;
   logic                    sdo_reg;
   logic                    sdo_oe_reg;
   logic [7:0]              cmd_byte;
   logic [`DCRC_ADDR_W-1:0] cmd_addr;
   logic [`DCRC_OP_W-1:0]   cmd_op;
   logic                    cmd_ok;
   logic [3:0]              rd_idx;

   function automatic logic addr_valid(input logic [`DCRC_ADDR_W-1:0] a);
      logic v;
      v = (a == `DCRC_ADDR_CH0) || (a == `DCRC_ADDR_VREF) ||
          (a == `DCRC_ADDR_PD) || (a == `DCRC_ADDR_GAIN);
      if (CHANNELS > 1 && a == `DCRC_ADDR_CH1) begin
         v = 1'b1;
      end
      return v;
   endfunction

   assign sync_in = {wr_flag_reg, spi_cs_n, latch_update_pin_n, supply_dropout_event};
   assign drop_s  = sync_out[0];
   assign lat_n_s = sync_out[1];
   assign cs_n_s  = sync_out[2];
   assign tog_s   = sync_out[3];

   // Idle levels: pins high, dropout and write flag low
   dcrc_sync #(
      .WIDTH   (4),
      .RST_VAL (4'h6)
   ) u_sync (
      .clk      (sys_clk),
      .reset    (reset),
      .async_in (sync_in),
      .sync_out (sync_out)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         drop_d_reg <= 1'b0;
         tog_d_reg  <= 1'b0;
      end else begin
         drop_d_reg <= drop_s;
         tog_d_reg  <= tog_s;
      end
   end

   // Supply recovery repeats the power-on sequence
   assign drop_fall = drop_d_reg & ~drop_s;
   assign por_load  = reset | drop_fall;
   // Frame word is stable once the flag's rise has been seen
   assign wr_accept = tog_s && !tog_d_reg && (pwr_reg == dcrc_pkg::PWR_RUN);

   always_ff @(posedge sys_clk) begin
      if (por_load) begin
         pwr_reg <= dcrc_pkg::PWR_DELAY;
      end else if (drop_s) begin
         pwr_reg <= dcrc_pkg::PWR_DROP;
      end else begin
         case (pwr_reg)
            dcrc_pkg::PWR_DELAY: if (timer_done) begin
               pwr_reg <= dcrc_pkg::PWR_RUN;
            end
            dcrc_pkg::PWR_RUN:   pwr_reg <= dcrc_pkg::PWR_RUN;
            dcrc_pkg::PWR_DROP:  pwr_reg <= dcrc_pkg::PWR_DELAY;
            default:             pwr_reg <= dcrc_pkg::PWR_DELAY;
         endcase
      end
   end

   dcrc_delay_timer #(
      .CYCLES (DELAY_CYCLES)
   ) u_delay (
      .clk     (sys_clk),
      .restart (por_load || drop_s || pwr_reg != dcrc_pkg::PWR_DELAY),
      .done    (timer_done)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= (pwr_reg == dcrc_pkg::PWR_RUN) && !drop_s;
      end
   end

   // Staging registers take host writes
   always_ff @(posedge sys_clk) begin
      if (por_load) begin
         for (int c = 0; c < CHANNELS; c++) begin
            stage_val_reg[c]  <= MID_SCALE;
            stage_vref_reg[c] <= `DCRC_SEL_RESET;
            stage_pd_reg[c]   <= `DCRC_SEL_RESET;
         end
         stage_gain_reg <= '0;
      end else if (drop_s) begin
         for (int c = 0; c < CHANNELS; c++) begin
            stage_val_reg[c]  <= '0;
            stage_vref_reg[c] <= `DCRC_SEL_RESET;
            stage_pd_reg[c]   <= `DCRC_PD_OFF;
         end
         stage_gain_reg <= '0;
      end else if (wr_accept) begin
         for (int c = 0; c < CHANNELS; c++) begin
            if (wr_word_reg.addr == `DCRC_ADDR_CH0 + `DCRC_ADDR_W'(c)) begin
               stage_val_reg[c] <= wr_word_reg.data[RES_BITS-1:0];
            end
            if (wr_word_reg.addr == `DCRC_ADDR_VREF) begin
               stage_vref_reg[c] <= wr_word_reg.data[c*`DCRC_SEL_W +: `DCRC_SEL_W];
            end
            if (wr_word_reg.addr == `DCRC_ADDR_PD) begin
               stage_pd_reg[c] <= wr_word_reg.data[c*`DCRC_SEL_W +: `DCRC_SEL_W];
            end
         end
         if (wr_word_reg.addr == `DCRC_ADDR_GAIN) begin
            stage_gain_reg <= wr_word_reg.data[`DCRC_GAIN_LSB +: CHANNELS];
         end
      end
   end

   // Output registers move together while the latch pin is low; power-on and dropout load them whatever the pin
   always_ff @(posedge sys_clk) begin
      if (por_load) begin
         for (int c = 0; c < CHANNELS; c++) begin
            act_val_reg[c]  <= MID_SCALE;
            act_vref_reg[c] <= `DCRC_SEL_RESET;
            act_pd_reg[c]   <= `DCRC_SEL_RESET;
         end
         act_gain_reg <= '0;
      end else if (drop_s) begin
         for (int c = 0; c < CHANNELS; c++) begin
            act_val_reg[c]  <= '0;
            act_vref_reg[c] <= `DCRC_SEL_RESET;
            act_pd_reg[c]   <= `DCRC_PD_OFF;
         end
         act_gain_reg <= '0;
      end else if (!lat_n_s) begin
         act_val_reg  <= stage_val_reg;
         act_vref_reg <= stage_vref_reg;
         act_pd_reg   <= stage_pd_reg;
         act_gain_reg <= stage_gain_reg;
      end
   end

   // Power-on flag; software clears it by writing zero to its bit
   always_ff @(posedge sys_clk) begin
      if (por_load) begin
         por_reg <= 1'b1;
      end else if (wr_accept && wr_word_reg.addr == `DCRC_ADDR_GAIN &&
                   !wr_word_reg.data[`DCRC_POR_BIT]) begin
         por_reg <= 1'b0;
      end
   end

   // Readback image, frozen while a frame is open so the link sees stable words
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         shadow_reg <= '0;
      end else if (cs_n_s) begin
         shadow_reg      <= '0;
         shadow_reg.ch0  <= `DCRC_WORD_W'(act_val_reg[0]);
         if (CHANNELS > 1) begin
            shadow_reg.ch1 <= `DCRC_WORD_W'(act_val_reg[CHANNELS-1]);
         end
         shadow_reg.vref <= `DCRC_WORD_W'(act_vref_reg);
         shadow_reg.pd   <= `DCRC_WORD_W'(act_pd_reg);
         shadow_reg.gain[`DCRC_GAIN_LSB +: CHANNELS] <= act_gain_reg;
         shadow_reg.gain[`DCRC_POR_BIT] <= por_reg;
      end
   end

   // ---------------- Link logic on the host clock ----------------
   // Chip select high clears all of it except the write word; the host clock stops between frames
   assign cmd_byte = {cmd_shift_reg, spi_sdi};
   assign cmd_addr = cmd_byte[`DCRC_CMD_ADDR_LSB +: `DCRC_ADDR_W];
   assign cmd_op   = cmd_byte[`DCRC_CMD_OP_LSB +: `DCRC_OP_W];
   assign cmd_ok   = addr_valid(cmd_addr) && rdy_sync_reg &&
                     (cmd_op == `DCRC_OP_WRITE || cmd_op == `DCRC_OP_READ);
   assign rd_idx   = 4'(`DCRC_FRAME_LAST - bit_cnt_reg);

   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         rdy_meta_reg <= 1'b0;
         rdy_sync_reg <= 1'b0;
      end else begin
         rdy_meta_reg <= ready_reg;
         rdy_sync_reg <= rdy_meta_reg;
      end
   end

   // Pointer starts at zero for every frame; chip select high clears it, power-on reset does not
   always_ff @(posedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         link_reg       <= dcrc_pkg::LINK_CMD;
         bit_cnt_reg    <= '0;
         cmd_shift_reg  <= '0;
         data_shift_reg <= '0;
         addr_reg       <= `DCRC_ADDR_CH0;
         op_write_reg   <= 1'b0;
         command_error_flag <= 1'b0;
         wr_flag_reg    <= 1'b0;
         rd_word_reg    <= '0;
      end else begin
         case (link_reg)
            dcrc_pkg::LINK_CMD: begin
               bit_cnt_reg   <= bit_cnt_reg + 5'h01;
               cmd_shift_reg <= cmd_byte[6:0];
               if (bit_cnt_reg == `DCRC_CMD_LAST) begin
                  link_reg     <= dcrc_pkg::LINK_DATA;
                  addr_reg     <= cmd_addr;
                  op_write_reg <= (cmd_op == `DCRC_OP_WRITE);
                  command_error_flag <= !cmd_ok;
                  rd_word_reg  <= '0;
                  if (cmd_ok && cmd_op == `DCRC_OP_READ) begin
                     case (cmd_addr)
                        `DCRC_ADDR_CH0:  rd_word_reg <= shadow_reg.ch0;
                        `DCRC_ADDR_CH1:  rd_word_reg <= shadow_reg.ch1;
                        `DCRC_ADDR_VREF: rd_word_reg <= shadow_reg.vref;
                        `DCRC_ADDR_PD:   rd_word_reg <= shadow_reg.pd;
                        `DCRC_ADDR_GAIN: rd_word_reg <= shadow_reg.gain;
                        default:         rd_word_reg <= '0;
                     endcase
                  end
               end
            end
            dcrc_pkg::LINK_DATA: begin
               bit_cnt_reg    <= bit_cnt_reg + 5'h01;
               data_shift_reg <= {data_shift_reg[`DCRC_WORD_W-3:0], spi_sdi};
               if (bit_cnt_reg == `DCRC_FRAME_LAST) begin
                  link_reg <= dcrc_pkg::LINK_DONE;
                  wr_flag_reg <= op_write_reg && !command_error_flag;
               end
            end
            dcrc_pkg::LINK_DONE: link_reg <= dcrc_pkg::LINK_DONE;
            default:             link_reg <= dcrc_pkg::LINK_CMD;
         endcase
      end
   end

   // Word waits here; its flag dies with chip select, so the host keeps
   // chip select low two core cycles past the last clock edge
   always_ff @(posedge spi_sck) begin
      if (link_reg == dcrc_pkg::LINK_DATA && bit_cnt_reg == `DCRC_FRAME_LAST &&
          op_write_reg && !command_error_flag) begin
         wr_word_reg <= '{addr: addr_reg, data: {data_shift_reg, spi_sdi}};
      end
   end

   // Data out changes on the falling edge, one bit per data cycle
   always_ff @(negedge spi_sck or posedge spi_cs_n) begin
      if (spi_cs_n) begin
         sdo_reg    <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else begin
         sdo_oe_reg <= 1'b1;
         if (link_reg == dcrc_pkg::LINK_DATA && !command_error_flag) begin
            sdo_reg <= rd_word_reg[rd_idx];
         end else begin
            sdo_reg <= 1'b0;
         end
      end
   end

   // Outputs come straight from registers
   assign spi_sdo                 = sdo_reg;
   assign spi_sdo_oe              = sdo_oe_reg;
   assign channel_value           = act_val_reg;
   assign reference_select_field  = act_vref_reg;
   assign power_down_select_field = act_pd_reg;
   assign gain_select_bit         = act_gain_reg;
   assign por_status              = por_reg;
   assign link_ready              = ready_reg;

endmodule

// file: bench/dcrc_core_checker.sv
// Purpose: Port assertions for the converter control core
// Assumes: Only the core's ports are visible; all checks on sys_clk
// Notes:   Margins of 6 and 8 cycles cover the two-flop input synchronisers
`timescale 1ns/1ps

module dcrc_core_checker #(
   parameter int unsigned RES_BITS     = 12,
   parameter int unsigned CHANNELS     = 2,
   parameter int unsigned DELAY_CYCLES = 200
) (
   input wire logic                              sys_clk,
   input wire logic                              reset,
   input wire logic                              supply_dropout_event,
   input wire logic                              latch_update_pin_n,
   input wire logic                              spi_sck,
   input wire logic                              spi_cs_n,
   input wire logic                              spi_sdi,
   input wire logic                              spi_sdo,
   input wire logic                              spi_sdo_oe,
   input wire logic [CHANNELS-1:0][RES_BITS-1:0] channel_value,
   input wire logic [CHANNELS-1:0][1:0]          reference_select_field,
   input wire logic [CHANNELS-1:0][1:0]          power_down_select_field,
   input wire logic [CHANNELS-1:0]               gain_select_bit,
   input wire logic                              por_status,
   input wire logic                              link_ready
);
   localparam logic [RES_BITS-1:0] MID       = {1'b0, {(RES_BITS-1){1'b1}}};
   localparam int                  READY_MAX = DELAY_CYCLES + 8;

   chk_reset_defaults: assert property (
      @(posedge sys_clk) disable iff (supply_dropout_event)
      reset |=> channel_value == {CHANNELS{MID}} && por_status && gain_select_bit == '0
         && reference_select_field == '0 && power_down_select_field == '0)
      else $error("Reset defaults missing");
   chk_ready_delay: assert property (
      @(posedge sys_clk) disable iff (reset || supply_dropout_event)
      $fell(reset) |-> (!link_ready)[*8] ##[1:READY_MAX] link_ready)
      else $error("Link ready timing wrong");
   chk_drop_link_off: assert property (
      @(posedge sys_clk) disable iff (reset)
      supply_dropout_event[*6] |-> !link_ready)
      else $error("Link still ready in dropout");
   chk_drop_pd_off: assert property (
      @(posedge sys_clk) disable iff (reset)
      supply_dropout_event[*6] |-> power_down_select_field == {CHANNELS{2'h3}})
      else $error("Power-down not forced in dropout");
   chk_drop_value_zero: assert property (
      @(posedge sys_clk) disable iff (reset)
      supply_dropout_event[*6] |-> channel_value == '0)
      else $error("Values not cleared in dropout");
   chk_drop_sel_zero: assert property (
      @(posedge sys_clk) disable iff (reset)
      supply_dropout_event[*6] |-> reference_select_field == '0 && gain_select_bit == '0)
      else $error("Selections not cleared in dropout");
   chk_latch_hold: assert property (
      @(posedge sys_clk) disable iff (reset)
      (latch_update_pin_n && !supply_dropout_event)[*8]
         |-> $stable(channel_value) && $stable(power_down_select_field))
      else $error("Outputs moved with latch pin high");
   chk_idle_sdo_quiet: assert property (
      @(posedge sys_clk) disable iff (reset)
      spi_cs_n |-> !spi_sdo_oe && !spi_sdo)
      else $error("Data out active while deselected");
endmodule

bind dcrc_core dcrc_core_checker #(
   .RES_BITS(RES_BITS), .CHANNELS(CHANNELS), .DELAY_CYCLES(DELAY_CYCLES)
) dcrc_core_checker_i (
   .sys_clk(sys_clk), .reset(reset), .supply_dropout_event(supply_dropout_event),
   .latch_update_pin_n(latch_update_pin_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
   .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
   .channel_value(channel_value), .reference_select_field(reference_select_field),
   .power_down_select_field(power_down_select_field), .gain_select_bit(gain_select_bit),
   .por_status(por_status), .link_ready(link_ready)
);

// file: bench/dcrc_spi_host.sv
// Purpose: SPI mode 0 host model for the converter core
// Assumes: 12 ns serial clock, idle low and still outside frames
// Notes:   Released data line shows the inverse of its last bit
`timescale 1ns/1ps

module dcrc_spi_host (
   output logic        sck,
   output logic        cs_n,
   output logic        sdi,
   input  wire logic   sdo,
   output logic [15:0] rd_word,
   output logic        rd_valid
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b0;
      sdi = 1'b0;
      rd_word = 16'h0000;
      rd_valid = 1'b0;
      #1 cs_n = 1'b1;
   end

   task automatic frame(input logic [7:0] cmd, input logic [15:0] data, input logic rd);
      logic [23:0] bits;
      bits = {cmd, data};
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdi = bits[i];
         #6 sck = 1'b1;
         if (i < 16) rd_word[i] = sdo;
         #6 sck = 1'b0;
      end
      #6 cs_n = 1'b1;
      sdi = ~sdi;
      rd_valid = rd;
      #1 rd_valid = 1'b0;
      #12;
   endtask
endmodule

// file: bench/dcrc_core_bench.sv
// Purpose: Self-checking bench for the converter control core
// Assumes: Short reset delay; host model on a 12 ns serial clock
// Notes:   Read results are matched against a queue of expectations
`timescale 1ns/1ps

module dcrc_core_bench;
   localparam int unsigned CH  = 2;
   localparam int unsigned RES = 12;
   logic                   sys_clk, reset, drop, lat_n, sck, cs_n, sdi, sdo, sdo_oe;
   logic                   por, rdy, rd_valid;
   logic [CH-1:0][RES-1:0] chv;
   logic [CH-1:0][1:0]     refs, pds;
   logic [CH-1:0]          gains;
   logic [15:0]            rd_word;
   logic [15:0]            expq[$];
   logic [11:0]            v0, v1;
   logic [7:0]             sel;
   logic [4:0]             amap[5] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h0A};
   logic [15:0]            dflt[5] = '{16'h07FF, 16'h07FF, 16'h0000, 16'h0000, 16'h0080};
   logic [4:0]             rsv[5] = '{5'h02, 5'h07, 5'h0B, 5'h10, 5'h1F};
   int                     fails, n_compared, cycles, seed;

   dcrc_core #(.RES_BITS(RES), .CHANNELS(CH), .DELAY_CYCLES(40)) dcrc_core_i (
      .sys_clk(sys_clk), .reset(reset), .supply_dropout_event(drop),
      .latch_update_pin_n(lat_n), .spi_sck(sck), .spi_cs_n(cs_n), .spi_sdi(sdi),
      .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .channel_value(chv),
      .reference_select_field(refs), .power_down_select_field(pds),
      .gain_select_bit(gains), .por_status(por), .link_ready(rdy));
   dcrc_spi_host dcrc_spi_host_i (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .rd_word(rd_word), .rd_valid(rd_valid));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish();
      if (expq.size() != 0) fails++;
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
      cmp(32'(got), 32'(exp));
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      dcrc_spi_host_i.frame({a, 2'h0, 1'b0}, d, 1'b0);
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      expq.push_back(e);
      dcrc_spi_host_i.frame({a, 2'h3, 1'b0}, 16'h0000, 1'b1);
   endtask

   task automatic wait_ready();
      int k;
      k = 0;
      while (rdy !== 1'b1 && k < 200) begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 200) fails++;
      repeat (4) @(negedge sys_clk);
   endtask

   // Oldest note pairs with each finished read
   always @(posedge rd_valid) begin
      if (expq.size() == 0) fails++;
      else cmp_rd(rd_word, expq.pop_front());
   end

   // Hang guard, well above the roughly 1800 cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 71;
      fails = 0;
      n_compared = 0;
      cycles = 0;
      reset = 1'b1;
      drop = 1'b0;
      lat_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      reset = 1'b0;
      cmp(32'({chv, por}), {7'h00, {CH{12'h7FF}}, 1'b1});
      wr(5'h00, 16'h0123);
      wait_ready();
      for (int i = 0; i < 5; i++) rd(amap[i], dflt[i]);
      @(negedge sys_clk);
      lat_n = 1'b1;
      v0 = 12'($random(seed));
      v1 = 12'($random(seed));
      sel = 8'($random(seed));
      wr(5'h00, {4'hF, v0});
      wr(5'h01, {4'h0, v1});
      wr(5'h08, {12'h000, sel[3:0]});
      wr(5'h09, {12'h000, sel[7:4]});
      wr(5'h0A, {6'h00, sel[1:0], 8'h80});
      repeat (20) @(negedge sys_clk);
      cmp(32'({chv, pds}), {4'h0, {CH{12'h7FF}}, 4'h0});
      lat_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      cmp(32'(chv), {8'h00, v1, v0});
      cmp(32'({refs, pds, gains}), {22'h0, sel[3:0], sel[7:4], sel[1:0]});
      rd(5'h00, {4'h0, v0});
      rd(5'h0A, {6'h00, sel[1:0], 8'h80});
      wr(5'h0A, {6'h00, sel[1:0], 8'h00});
      repeat (10) @(negedge sys_clk);
      cmp(32'(por), 32'h0);
      foreach (rsv[i]) begin
         wr(rsv[i], 16'hFFFF);
         rd(rsv[i], 16'h0000);
      end
      expq.push_back(16'h0000);
      dcrc_spi_host_i.frame({5'h00, 2'h1, 1'b0}, 16'h0000, 1'b1);
      repeat (10) @(negedge sys_clk);
      cmp(32'(chv), {8'h00, v1, v0});
      drop = 1'b1;
      repeat (8) @(negedge sys_clk);
      cmp(32'({chv, pds}), {4'h0, 24'h0, {CH{2'h3}}});
      cmp(32'({refs, gains, rdy}), 32'h0);
      rd(5'h00, 16'h0000);
      @(negedge sys_clk);
      drop = 1'b0;
      wait_ready();
      cmp(32'({chv, por}), {7'h00, {CH{12'h7FF}}, 1'b1});
      rd(5'h0A, 16'h0080);
      repeat (5) @(negedge sys_clk);
      tally_and_finish();
   end
endmodule
